// ==== rtl/fps_pkg.sv ====
// Constants shared by the fault protection sequencer.
package fps_pkg;
   // -----------------------------------------------------------------
   // Clock and timing
   // -----------------------------------------------------------------
   localparam int CLK_HZ = 25000000;
   localparam int OVERLOAD_DELAY_MS = 63;
   localparam longint OVERLOAD_DELAY_CYC = longint'(CLK_HZ) * OVERLOAD_DELAY_MS / 1000;
   localparam int OVL_CNT_W = 32;
   localparam logic [1:0] LOCKOUT_OFF_RELEASE_COUNT = 2'h2;
   localparam int SYNC_STAGES = 2;
endpackage

// ==== rtl/fps_sync.sv ====
// Two flip-flop synchroniser for a group of level flags.
`timescale 1ns/1ps
module fps_sync #(
   parameter int WIDTH = 4
) (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta;

   // An empty flag group has nothing to carry.
   if (WIDTH < 1) begin : g_width
      $error("WIDTH must be at least one");
   end

   // The first stage feeds only the second stage.
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         meta <= '0;
         sync_out <= '0;
      end else begin
         meta <= async_in;
         sync_out <= meta;
      end
   end
endmodule

// ==== rtl/fps_top.sv ====
// Protection sequencer that gates the power switch drive.
`timescale 1ns/1ps
module fps_top
   import fps_pkg::*;
#(
   parameter longint OVERLOAD_DELAY = fps_pkg::OVERLOAD_DELAY_CYC
) (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic feedback_voltage_high_in,
   input wire logic supply_overvoltage_in,
   input wire logic temp_sense_low_in,
   input wire logic supply_undervoltage_lockout_in,
   input wire logic power_down_reset_in,
   input wire logic pwm_in,
   output logic gate_drive_out,
   output logic drive_enable_out,
   output logic overload_protection_out,
   output logic overvoltage_latched_out,
   output logic over_temp_latched_out
);
   import fps_pkg::*;

   // ----------------------------------------------------------------
   // Parameter checks
   // ----------------------------------------------------------------
   // The timer stops at the delay, so the delay must fit in its width.
   if (OVERLOAD_DELAY < 1 || OVERLOAD_DELAY >= (longint'(1) << OVL_CNT_W)) begin : g_delay
      $error("OVERLOAD_DELAY out of range");
   end

   // The synchroniser is built with exactly two stages.
   if (SYNC_STAGES != 2) begin : g_stages
      $error("SYNC_STAGES must be two");
   end

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------
   // End point of the overload timer, shared by the count and the trip.
   function automatic logic timer_done(input logic [OVL_CNT_W-1:0] t);
      return t >= OVL_CNT_W'(OVERLOAD_DELAY);
   endfunction

   // True when one more counted turn-off releases the overload latch.
   function automatic logic release_due(input logic [1:0] count);
      return 2'(count + 2'h1) >= LOCKOUT_OFF_RELEASE_COUNT;
   endfunction

   // ----------------------------------------------------------------
   // Input synchronisation
   // ----------------------------------------------------------------
   logic [4:0] flags;
   logic fb_high, overvolt_flag, temp_low, supply_good, pdr_flag, lockout_flag;

   // Supply-good rather than lockout is synchronised, so that the cleared
   // synchroniser reads as lockout after reset and never enables the drive.
   fps_sync #(.WIDTH(5)) u_sync (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .async_in({feedback_voltage_high_in, supply_overvoltage_in, temp_sense_low_in,
                 !supply_undervoltage_lockout_in, power_down_reset_in}),
      .sync_out(flags)
   );
   assign {fb_high, overvolt_flag, temp_low, supply_good, pdr_flag} = flags;
   assign lockout_flag = !supply_good;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [OVL_CNT_W-1:0] ovl_timer;
      logic [1:0] lockout_off_count;
      logic ovl_latch;
      logic overvolt_latch;
      logic otp_latch;
      logic lockout_prev;
      logic gate;
   } fps_state_s;

   fps_state_s st, next_st;
   logic lockout_off_evt, lockout_on_evt, run;

   // Lockout asserted means supply below the turn-off level.
   assign lockout_off_evt = lockout_flag && !st.lockout_prev;
   assign lockout_on_evt = !lockout_flag && st.lockout_prev;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.lockout_prev = lockout_flag;
      // Timer restarts whenever the flag drops, so short bumps never trip.
      if (!fb_high || st.ovl_latch) begin
         next_st.ovl_timer = '0;
      end else if (!timer_done(st.ovl_timer)) begin
         next_st.ovl_timer = st.ovl_timer + 1'b1;
      end
      if (!st.ovl_latch && fb_high && timer_done(st.ovl_timer)) begin
         next_st.ovl_latch = 1'b1;
         next_st.lockout_off_count = '0;
      end else if (st.ovl_latch && lockout_off_evt) begin
         if (release_due(st.lockout_off_count)) begin
            next_st.ovl_latch = 1'b0;
            next_st.lockout_off_count = '0;
         end else begin
            next_st.lockout_off_count = st.lockout_off_count + 2'h1;
         end
      end
      // Set wins over the clear so a new trip is never lost.
      if (overvolt_flag) begin
         next_st.overvolt_latch = 1'b1;
      end else if (lockout_on_evt) begin
         next_st.overvolt_latch = 1'b0;
      end
      // A power-down only clears the latch once the sensor has recovered.
      if (temp_low) begin
         next_st.otp_latch = 1'b1;
      end else if (pdr_flag) begin
         next_st.otp_latch = 1'b0;
      end
      next_st.gate = run && pwm_in;
   end

   // Temperature latch is checked first and alone blocks any restart.
   assign run = !st.otp_latch && !lockout_flag && !st.ovl_latch && !st.overvolt_latch
                && !overvolt_flag;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st <= '{ovl_timer: '0, lockout_off_count: '0, ovl_latch: 1'b0,
                 overvolt_latch: 1'b0, otp_latch: 1'b0, lockout_prev: 1'b1, gate: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // The gate leaves a flip-flop that resets low, so it never floats.
   assign gate_drive_out = st.gate;
   assign drive_enable_out = run;
   assign overload_protection_out = st.ovl_latch;
   assign overvoltage_latched_out = st.overvolt_latch;
   assign over_temp_latched_out = st.otp_latch;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   // Flag still high with the timer at its end point.
   sequence s_ovl_expired;
      fb_high && !st.ovl_latch && st.ovl_timer == OVL_CNT_W'(OVERLOAD_DELAY);
   endsequence

   // A counted turn-off that is not yet the releasing one.
   sequence s_first_off;
      st.ovl_latch && lockout_off_evt && st.lockout_off_count == 2'h0;
   endsequence

   // The turn-off that completes the divide-by-two count.
   sequence s_second_off;
      st.ovl_latch && lockout_off_evt && st.lockout_off_count == 2'h1;
   endsequence

   a_ovl_trip_time: assert property (@(posedge clk_in) disable iff (!resetn_in)
      s_ovl_expired |=> st.ovl_latch)
      else $error("overload did not trip");
   a_ovl_no_early: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (!st.ovl_latch && st.ovl_timer < OVL_CNT_W'(OVERLOAD_DELAY)) |=> !$rose(st.ovl_latch))
      else $error("overload tripped early");
   a_ovl_timer_cap: assert property (@(posedge clk_in) disable iff (!resetn_in)
      st.ovl_timer <= OVL_CNT_W'(OVERLOAD_DELAY))
      else $error("overload timer overran");
   a_ovl_timer_clr: assert property (@(posedge clk_in) disable iff (!resetn_in)
      !fb_high |=> st.ovl_timer == '0)
      else $error("timer not cleared");
   a_ovl_gate_off: assert property (@(posedge clk_in) disable iff (!resetn_in)
      st.ovl_latch |=> !gate_drive_out)
      else $error("gate on in overload");
   a_ovl_release: assert property (@(posedge clk_in) disable iff (!resetn_in)
      s_second_off |=> !st.ovl_latch)
      else $error("overload not released");
   a_ovl_hold_one: assert property (@(posedge clk_in) disable iff (!resetn_in)
      s_first_off |=> st.ovl_latch)
      else $error("released on first off");
   a_ovl_count_step: assert property (@(posedge clk_in) disable iff (!resetn_in)
      s_first_off |=> st.lockout_off_count == 2'h1)
      else $error("first turn-off not counted");
   a_overvolt_stop: assert property (@(posedge clk_in) disable iff (!resetn_in)
      overvolt_flag |=> st.overvolt_latch && !gate_drive_out)
      else $error("overvoltage ignored");
   a_overvolt_recover: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (lockout_on_evt && !overvolt_flag) |=> !st.overvolt_latch)
      else $error("no overvoltage recovery");
   a_otp_latch: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (st.otp_latch && !pdr_flag) |=> st.otp_latch)
      else $error("otp latch lost");
   a_otp_clear: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (st.otp_latch && pdr_flag && !temp_low) |=> !st.otp_latch)
      else $error("otp latch not cleared");
   a_otp_set: assert property (@(posedge clk_in) disable iff (!resetn_in)
      temp_low |=> st.otp_latch ##1 !gate_drive_out)
      else $error("otp not set");
   a_otp_prio: assert property (@(posedge clk_in) disable iff (!resetn_in)
      st.otp_latch |-> !drive_enable_out)
      else $error("restart under otp");
   a_lockout_gate: assert property (@(posedge clk_in) disable iff (!resetn_in)
      lockout_flag |=> !gate_drive_out)
      else $error("gate on in lockout");
   a_gate_idle: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (!run || !pwm_in) |=> !gate_drive_out)
      else $error("gate not held low");
   a_gate_follow: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (run && pwm_in) |=> gate_drive_out)
      else $error("gate did not switch");
endmodule

// ==== tb/fps_comparators.sv ====
// Behavioural comparators on supply, feedback and temperature sense.
`timescale 1ns/1ps
module fps_comparators #(
   parameter int OV_MV = 25000
) (
   input wire logic [15:0] vcc_mv_in,
   input wire logic [15:0] comp_mv_in,
   input wire logic [15:0] otp_mv_in,
   output logic fb_high_out,
   output logic ov_out,
   output logic temp_low_out,
   output logic lockout_out,
   output logic pdr_out
);
   // Plain trips are continuous, so they hold a value from time zero.
   assign fb_high_out = comp_mv_in > 16'h1388;
   assign ov_out = vcc_mv_in > OV_MV[15:0];
   assign pdr_out = vcc_mv_in < 16'h1f40;
   // Hysteresis is held in the outputs themselves, so a level between the trips keeps state.
   initial begin
      lockout_out = 1'b1;
      temp_low_out = 1'b0;
   end
   always @* begin
      if (vcc_mv_in >= 16'h3e80) lockout_out = 1'b0;
      else if (vcc_mv_in <= 16'h2710) lockout_out = 1'b1;
      if (otp_mv_in < 16'h03b6) temp_low_out = 1'b1;
      else if (otp_mv_in > 16'h041a) temp_low_out = 1'b0;
   end
endmodule

// ==== tb/test_fault_protection_sequencer.sv ====
// Self-checking bench for the fault protection sequencer.
`timescale 1ns/1ps
module test_fault_protection_sequencer;
   import fps_pkg::*;
   localparam longint DELAY = 20;
   logic clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic pwm_in = 1'b0;
   logic last = 1'b0;
   logic [15:0] vcc = 16'h0000, comp = 16'h03e8, otp = 16'h07d0, lfsr = 16'hbe69;
   logic fb, ov, tl, uv, pd, gate, en, ovld, ovl, otl;
   int errors = 0, n_checks = 0, cycles = 0;
   initial forever #20 clk_in = ~clk_in;
   fps_comparators fps_comparators_i (.vcc_mv_in(vcc), .comp_mv_in(comp), .otp_mv_in(otp),
      .fb_high_out(fb), .ov_out(ov), .temp_low_out(tl), .lockout_out(uv), .pdr_out(pd));
   fps_top #(.OVERLOAD_DELAY(DELAY)) fps_top_i (.clk_in(clk_in), .resetn_in(resetn_in),
      .feedback_voltage_high_in(fb), .supply_overvoltage_in(ov), .temp_sense_low_in(tl),
      .supply_undervoltage_lockout_in(uv), .power_down_reset_in(pd), .pwm_in(pwm_in),
      .gate_drive_out(gate), .drive_enable_out(en), .overload_protection_out(ovld),
      .overvoltage_latched_out(ovl), .over_temp_latched_out(otl));
   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   function automatic logic [15:0] step(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic complete_run;
      if (errors == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic seen, input logic exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %b seen %b", what, exp, seen);
      end
   endtask
   // Random switching; a live gate repeats the pulse of the cycle before.
   task automatic run(input int n, input logic live, input logic chk);
      repeat (n) begin
         @(posedge clk_in);
         lfsr = step(lfsr);
         pwm_in <= lfsr[0];
         #1;
         if (chk) check("gate", gate, live & last);
         if (chk) check("enable", en, live);
         last = pwm_in;
      end
   endtask
   task automatic latches(input logic o, input logic v, input logic t);
      check("overload", ovld, o);
      check("overvoltage", ovl, v);
      check("overtemp", otl, t);
   endtask
   task automatic power(input logic [15:0] lo, input logic [15:0] hi);
      vcc <= lo;
      run(8, 1'b0, 1'b0);
      vcc <= hi;
      run(8, 1'b0, 1'b0);
   endtask
   always @(posedge clk_in) begin
      cycles++;
      if (cycles > 2000) begin
         errors++;
         complete_run();
      end
   end
   initial begin
      repeat (5) @(posedge clk_in);
      resetn_in <= 1'b1;
      run(4, 1'b0, 1'b1);
      power(16'h0000, 16'h4268);
      run(16, 1'b1, 1'b1);
      comp <= 16'h157c;
      run(10, 1'b1, 1'b1);
      comp <= 16'h03e8;
      run(12, 1'b1, 1'b1);
      comp <= 16'h157c;
      run(int'(DELAY) + SYNC_STAGES, 1'b1, 1'b1);
      run(8, 1'b0, 1'b0);
      run(8, 1'b0, 1'b1);
      latches(1'b1, 1'b0, 1'b0);
      comp <= 16'h03e8;
      power(16'h2328, 16'h4268);
      run(8, 1'b0, 1'b1);
      power(16'h2328, 16'h4268);
      run(16, 1'b1, 1'b1);
      latches(1'b0, 1'b0, 1'b0);
      power(16'h7530, 16'h4268);
      run(8, 1'b0, 1'b1);
      latches(1'b0, 1'b1, 1'b0);
      power(16'h2328, 16'h7530);
      latches(1'b0, 1'b1, 1'b0);
      power(16'h2328, 16'h4268);
      run(16, 1'b1, 1'b1);
      otp <= 16'h0384;
      power(16'h4268, 16'h4268);
      latches(1'b0, 1'b0, 1'b1);
      otp <= 16'h03e8;
      power(16'h1b58, 16'h4268);
      run(8, 1'b0, 1'b1);
      latches(1'b0, 1'b0, 1'b1);
      otp <= 16'h044c;
      power(16'h1b58, 16'h4268);
      run(16, 1'b1, 1'b1);
      complete_run();
   end
endmodule
